// file: src/ssp_top.sv
`timescale 1ns/1ns
`default_nettype none

module ssp_top import ssp_pkg::*; (
	// apb clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// interrupt
	output logic             irq,
	// serial pins
	input  wire ssp_pins_t   pin_i,
	output ssp_pins_t        pin_o,
	output ssp_pins_t        pin_oe
);

	// ==============================================================
	// decode helpers
	function automatic logic head_bit(input logic [SSP_DW-1:0] s, input logic [3:0] lm1, input logic msb);
		return msb ? s[lm1] : s[0];
	endfunction

	function automatic logic [SSP_DW-1:0] shift_in(input logic [SSP_DW-1:0] s, input logic b,
		input logic [3:0] lm1, input logic msb);
		logic [SSP_DW-1:0] r;
		if (msb) begin
			r = {s[SSP_DW-2:0], b};
		end else begin
			r      = s >> 1;
			r[lm1] = b;
		end
		return r;
	endfunction

	function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// ==============================================================
	// state
	ssp_ctrl_t         ctrl_r, ctrl_nxt;
	logic [15:0]       baud_r, baud_nxt;
	logic [15:0]       bcnt_r, bcnt_nxt;
	logic [2:0]        latch_r, latch_nxt;
	logic [2:0]        dir_r, dir_nxt;
	logic [SSP_DW-1:0] txbuf_r, txbuf_nxt;
	logic              tx_full_r, tx_full_nxt;
	logic [SSP_DW-1:0] rxbuf_r, rxbuf_nxt;
	logic [SSP_DW-1:0] sr_r, sr_nxt;
	logic              out_r, out_nxt;
	logic              inbit_r, inbit_nxt;
	logic              sclk_r, sclk_nxt;
	logic [4:0]        ecnt_r, ecnt_nxt;
	ssp_state_t        st_r, st_nxt;
	logic              busy_r, busy_nxt;
	logic [1:0]        stat_r, stat_nxt;
	logic [1:0]        mask_r, mask_nxt;
	logic [31:0]       prdata_r, prdata_nxt;
	ssp_pins_t         sync1_r, sync2_r;
	logic              sclk_d_r;

	logic              en, master, tick, sclk_edge, edge_go, is_sample, last_edge;
	logic              din, bit_in, tx_evt, rx_evt, wr_acc, rd_acc, mapped;
	logic [SSP_DW-1:0] sr_tmp;

	assign en     = ctrl_r.port_enable_bit;
	assign master = ctrl_r.role_select_bit;

	// ==============================================================
	// pin input synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r  <= '1;
			sync2_r  <= '1;
			sclk_d_r <= 1'b1;
		end else begin
			sync1_r  <= pin_i;
			sync2_r  <= sync1_r;
			sclk_d_r <= sync2_r.sclk;
		end
	end

	assign sclk_edge = sync2_r.sclk != sclk_d_r;
	assign din       = master ? sync2_r.miso : sync2_r.mosi;
	// baud tick every reload+1 cycles gives one clock half period
	assign tick      = bcnt_r == 16'h0000;
	assign edge_go   = master ? tick : sclk_edge;
	// phase 0 samples even (leading) edges, phase 1 odd (trailing)
	assign is_sample = ecnt_r[0] == ctrl_r.clock_phase_bit;
	assign last_edge = ecnt_r == {ctrl_r.len_m1, 1'b1};
	assign bit_in    = is_sample ? din : inbit_r;
	assign sr_tmp    = shift_in(sr_r, bit_in, ctrl_r.len_m1, ctrl_r.msb_first);

	// ==============================================================
	// transfer engine
	always_comb begin
		bcnt_nxt    = (!en || tick) ? baud_r : 16'(bcnt_r - 16'h0001);
		st_nxt      = st_r;
		sr_nxt      = sr_r;
		out_nxt     = out_r;
		inbit_nxt   = inbit_r;
		sclk_nxt    = sclk_r;
		ecnt_nxt    = ecnt_r;
		busy_nxt    = busy_r;
		tx_full_nxt = tx_full_r;
		rxbuf_nxt   = rxbuf_r;
		tx_evt      = 1'b0;
		rx_evt      = 1'b0;
		if (!en) begin
			st_nxt   = SSP_IDLE;
			busy_nxt = 1'b0;
			ecnt_nxt = SSP_ECNT_RST;
			// next polarity, so the clock is already idle in the first enabled cycle
			sclk_nxt = ctrl_nxt.clock_idle_polarity_bit;
		end else begin
			case (st_r)
				SSP_IDLE: begin
					if (tx_full_r) begin
						sr_nxt      = txbuf_r;
						tx_full_nxt = 1'b0;
						busy_nxt    = 1'b1;
						tx_evt      = 1'b1;
						ecnt_nxt    = SSP_ECNT_RST;
						if (master) begin
							st_nxt = SSP_START;
						end else begin
							out_nxt = head_bit(txbuf_r, ctrl_r.len_m1, ctrl_r.msb_first);
							st_nxt  = SSP_SHIFT;
						end
					end else if (!master && sclk_edge && sync2_r.sclk != ctrl_r.clock_idle_polarity_bit) begin
						// slave with nothing loaded still exchanges its old register
						busy_nxt = 1'b1;
						st_nxt   = SSP_SHIFT;
						ecnt_nxt = 5'h01;
						if (is_sample) begin
							inbit_nxt = din;
						end
					end
				end
				SSP_START: begin
					if (tick) begin
						out_nxt = head_bit(sr_r, ctrl_r.len_m1, ctrl_r.msb_first);
						st_nxt  = SSP_SHIFT;
						if (ctrl_r.clock_phase_bit) begin
							sclk_nxt = ~sclk_r;
							ecnt_nxt = 5'h01;
						end
					end
				end
				SSP_SHIFT: begin
					if (edge_go) begin
						if (master) begin
							sclk_nxt = ~sclk_r;
						end
						if (is_sample) begin
							inbit_nxt = din;
						end
						if (last_edge) begin
							rxbuf_nxt = sr_tmp;
							rx_evt    = 1'b1;
							ecnt_nxt  = SSP_ECNT_RST;
							if (tx_full_r) begin
								// back-to-back frame, no gap on the line
								sr_nxt      = txbuf_r;
								out_nxt     = head_bit(txbuf_r, ctrl_r.len_m1, ctrl_r.msb_first);
								tx_full_nxt = 1'b0;
								tx_evt      = 1'b1;
							end else begin
								sr_nxt   = sr_tmp;
								busy_nxt = 1'b0;
								st_nxt   = SSP_IDLE;
							end
						end else begin
							ecnt_nxt = 5'(ecnt_r + 5'h01);
							if (!is_sample && ecnt_r != SSP_ECNT_RST) begin
								sr_nxt  = sr_tmp;
								out_nxt = head_bit(sr_tmp, ctrl_r.len_m1, ctrl_r.msb_first);
							end
						end
					end
				end
				default: begin
					st_nxt = SSP_IDLE;
				end
			endcase
		end
		// a new transmit write always wins over the engine's take
		if (wr_acc && is_reg(paddr, SSP_OFF_TXBUF)) begin
			tx_full_nxt = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bcnt_r    <= SSP_BAUD_RST;
			st_r      <= SSP_IDLE;
			sr_r      <= '0;
			out_r     <= 1'b1;
			inbit_r   <= 1'b0;
			sclk_r    <= 1'b1;
			ecnt_r    <= SSP_ECNT_RST;
			busy_r    <= 1'b0;
			tx_full_r <= 1'b0;
			rxbuf_r   <= '0;
		end else begin
			bcnt_r    <= bcnt_nxt;
			st_r      <= st_nxt;
			sr_r      <= sr_nxt;
			out_r     <= out_nxt;
			inbit_r   <= inbit_nxt;
			sclk_r    <= sclk_nxt;
			ecnt_r    <= ecnt_nxt;
			busy_r    <= busy_nxt;
			tx_full_r <= tx_full_nxt;
			rxbuf_r   <= rxbuf_nxt;
		end
	end

	// ==============================================================
	// apb register file
	assign wr_acc  = psel && penable && pwrite;
	assign rd_acc  = psel && penable && !pwrite;
	assign mapped  = is_reg(paddr, SSP_OFF_CTRL) || is_reg(paddr, SSP_OFF_BAUD) ||
		is_reg(paddr, SSP_OFF_TXBUF) || is_reg(paddr, SSP_OFF_RXBUF) ||
		is_reg(paddr, SSP_OFF_STATUS) || is_reg(paddr, SSP_OFF_MASK) || is_reg(paddr, SSP_OFF_PORT);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = prdata_r;

	always_comb begin
		ctrl_nxt   = ctrl_r;
		baud_nxt   = baud_r;
		txbuf_nxt  = txbuf_r;
		mask_nxt   = mask_r;
		latch_nxt  = latch_r;
		dir_nxt    = dir_r;
		prdata_nxt = prdata_r;
		stat_nxt   = stat_r;
		if (rd_acc && is_reg(paddr, SSP_OFF_STATUS)) begin
			stat_nxt = SSP_STAT_RST;
		end
		// set beats the read clear in the same cycle
		if (tx_evt) begin
			stat_nxt[SSP_ST_TX_BIT] = 1'b1;
		end
		if (rx_evt) begin
			stat_nxt[SSP_ST_RX_BIT] = 1'b1;
		end
		if (wr_acc) begin
			if (is_reg(paddr, SSP_OFF_CTRL)) begin
				ctrl_nxt = ssp_ctrl_t'(pwdata[SSP_CTRL_W-1:0]);
				// a 1-bit frame is not supported; clamp to 2 bits
				if (pwdata[3:0] == 4'h0) begin
					ctrl_nxt.len_m1 = 4'h1;
				end
			end
			if (is_reg(paddr, SSP_OFF_BAUD) && !en) begin
				baud_nxt = pwdata[15:0];
			end
			if (is_reg(paddr, SSP_OFF_TXBUF)) begin
				txbuf_nxt = pwdata[SSP_DW-1:0];
			end
			if (is_reg(paddr, SSP_OFF_MASK)) begin
				mask_nxt = pwdata[1:0];
			end
			if (is_reg(paddr, SSP_OFF_PORT)) begin
				latch_nxt = pwdata[2:0];
				dir_nxt   = pwdata[SSP_PORT_DIR_LSB+2:SSP_PORT_DIR_LSB];
			end
		end
		// read data captured in the setup cycle
		if (psel && !penable && !pwrite) begin
			prdata_nxt = 32'h0000_0000;
			case (paddr)
				SSP_OFF_CTRL: begin
					prdata_nxt[SSP_CTRL_W-1:0]   = ctrl_r;
					prdata_nxt[SSP_CTRL_BUSY_BIT] = busy_r;
					prdata_nxt[SSP_CTRL_FULL_BIT] = tx_full_r;
				end
				SSP_OFF_BAUD: begin
					prdata_nxt[15:0] = en ? bcnt_r : baud_r;
				end
				SSP_OFF_TXBUF: begin
					prdata_nxt[SSP_DW-1:0] = txbuf_r;
				end
				SSP_OFF_RXBUF: begin
					prdata_nxt[SSP_DW-1:0] = rxbuf_r;
				end
				SSP_OFF_STATUS: begin
					prdata_nxt[1:0] = stat_r;
				end
				SSP_OFF_MASK: begin
					prdata_nxt[1:0] = mask_r;
				end
				SSP_OFF_PORT: begin
					prdata_nxt[2:0]                                 = latch_r;
					prdata_nxt[SSP_PORT_DIR_LSB+2:SSP_PORT_DIR_LSB] = dir_r;
				end
				default: begin
					prdata_nxt = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r   <= ssp_ctrl_t'(SSP_CTRL_RST);
			baud_r   <= SSP_BAUD_RST;
			txbuf_r  <= '0;
			mask_r   <= SSP_STAT_RST;
			stat_r   <= SSP_STAT_RST;
			latch_r  <= SSP_LATCH_RST;
			dir_r    <= SSP_DIR_RST;
			prdata_r <= 32'h0000_0000;
		end else begin
			ctrl_r   <= ctrl_nxt;
			baud_r   <= baud_nxt;
			txbuf_r  <= txbuf_nxt;
			mask_r   <= mask_nxt;
			stat_r   <= stat_nxt;
			latch_r  <= latch_nxt;
			dir_r    <= dir_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	assign irq = |(stat_r & mask_r);

	// ==============================================================
	// pin control: unused alternate outputs idle high so the latch rules
	always_comb begin
		pin_o.sclk = latch_r[0] & ((en && master) ? sclk_r : 1'b1);
		pin_o.mosi = latch_r[1] & ((en && master) ? out_r : 1'b1);
		pin_o.miso = latch_r[2] & ((en && !master) ? out_r : 1'b1);
		// direction is software's: role hand-over and slave select do not flip it
		pin_oe.sclk = dir_r[0];
		pin_oe.mosi = dir_r[1];
		pin_oe.miso = dir_r[2];
	end

endmodule

`default_nettype wire

// file: src/ssp_pkg.sv
package ssp_pkg;

	// ==============================================================
	// register map (byte addresses)
	localparam logic [7:0] SSP_OFF_CTRL   = 8'h00;
	localparam logic [7:0] SSP_OFF_BAUD   = 8'h04;
	localparam logic [7:0] SSP_OFF_TXBUF  = 8'h08;
	localparam logic [7:0] SSP_OFF_RXBUF  = 8'h0C;
	localparam logic [7:0] SSP_OFF_STATUS = 8'h10;
	localparam logic [7:0] SSP_OFF_MASK   = 8'h14;
	localparam logic [7:0] SSP_OFF_PORT   = 8'h18;

	// ==============================================================
	// field positions
	localparam int SSP_CTRL_W        = 9;
	localparam int SSP_CTRL_BUSY_BIT = 12;
	localparam int SSP_CTRL_FULL_BIT = 13;
	localparam int SSP_ST_TX_BIT     = 0;
	localparam int SSP_ST_RX_BIT     = 1;
	localparam int SSP_PORT_DIR_LSB  = 4;

	// ==============================================================
	// reset values and widths
	localparam int          SSP_DW        = 16;
	localparam logic [8:0]  SSP_CTRL_RST  = 9'h001;
	localparam logic [15:0] SSP_BAUD_RST  = 16'h0000;
	localparam logic [2:0]  SSP_LATCH_RST = 3'h0;
	localparam logic [2:0]  SSP_DIR_RST   = 3'h0;
	localparam logic [1:0]  SSP_STAT_RST  = 2'h0;
	localparam logic [4:0]  SSP_ECNT_RST  = 5'h00;

	// control register layout
	typedef struct packed {
		logic       port_enable_bit;
		logic       role_select_bit;
		logic       clock_idle_polarity_bit;
		logic       clock_phase_bit;
		logic       msb_first;
		logic [3:0] len_m1;
	} ssp_ctrl_t;

	// pin triple: {sclk, master_out_slave_in, master_in_slave_out}
	typedef struct packed {
		logic sclk;
		logic mosi;
		logic miso;
	} ssp_pins_t;

	typedef enum logic [1:0] {
		SSP_IDLE,
		SSP_START,
		SSP_SHIFT
	} ssp_state_t;

endpackage

// file: verification/ssp_checker.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_checker import ssp_pkg::*; (
	// apb side
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	input wire logic        irq,
	// pins
	input wire ssp_pins_t   pin_i,
	input wire ssp_pins_t   pin_o,
	input wire ssp_pins_t   pin_oe
);
	// ====================
	// register shadows
	logic       wr_c, wr_p, wr_t, wr_m;
	logic [8:0] ctl_r, ctl_nxt;
	logic [2:0] lat_r, lat_nxt;
	ssp_pins_t  lat;
	always_comb begin
		wr_c = psel && penable && pwrite && paddr == SSP_OFF_CTRL;
		wr_p = psel && penable && pwrite && paddr == SSP_OFF_PORT;
		wr_t = psel && penable && pwrite && paddr == SSP_OFF_TXBUF;
		wr_m = psel && penable && pwrite && paddr == SSP_OFF_MASK;
		ctl_nxt = wr_c ? pwdata[8:0] : ctl_r;
		lat_nxt = wr_p ? pwdata[2:0] : lat_r;
		lat = {lat_r[0], lat_r[1], lat_r[2]};
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_r <= SSP_CTRL_RST;
			lat_r <= SSP_LATCH_RST;
		end else begin
			ctl_r <= ctl_nxt;
			lat_r <= lat_nxt;
		end
	end
	// ====================
	// properties
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_always: assert property (psel |-> pready) else $error("pready low");
	a_err_unmapped: assert property (psel && penable && paddr > SSP_OFF_PORT |-> pslverr) else $error("no slverr");
	a_oe_from_port: assert property (!wr_p |=> $stable(pin_oe)) else $error("enables moved");
	a_disabled_pass: assert property (!ctl_r[8] |-> pin_o == lat) else $error("disabled pin level");
	a_slave_clock_in: assert property (ctl_r[8] && !ctl_r[7] |->
		pin_o.sclk == lat_r[0] && pin_o.mosi == lat_r[1]) else $error("slave drove clock");
	a_master_miso_one: assert property (ctl_r[8] && ctl_r[7] |-> pin_o.miso == lat_r[2]) else $error("master miso");
	a_enable_idle: assert property (wr_c && pwdata[8] && pwdata[7] && !ctl_r[8] |=>
		pin_o.sclk == ($past(pwdata[6]) & lat_r[0])) else $error("clock not at idle level");
	a_first_bit_wait: assert property (wr_t && ctl_r[8] && ctl_r[7] |=> $stable(pin_o.mosi))
		else $error("mosi moved before tick");
	a_mask_quiet: assert property (wr_m && pwdata[1:0] == 2'b00 |=> !irq) else $error("masked irq");
	c_rx_irq: cover property ($rose(irq));
	c_slave_clk: cover property (ctl_r[8] && !ctl_r[7] && $changed(pin_i.sclk));
	c_idle_high: cover property (wr_c && pwdata[8] && pwdata[6]);
endmodule
`default_nettype wire

// file: verification/ssp_peer.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_peer (
	// link
	input wire logic        sclk,
	input wire logic        mosi,
	output logic            miso,
	// setup
	input wire logic        cpol,
	input wire logic        cpha,
	input wire logic [4:0]  len,
	input wire logic [15:0] tx,
	input wire logic        load,
	output logic [15:0]     rx
);
	// ====================
	// slave shifter, msb first
	logic [15:0] sh;
	int          n;
	always @(posedge load) begin
		sh = tx;
		n = 0;
	end
	always @(sclk) begin
		if ((sclk != cpol) != cpha) begin
			rx = {rx[14:0], mosi};
			n++;
		end else if (n > 0 && n < len) begin
			sh = sh << 1;
		end
	end
	// first bit is out before any edge; after the frame the old bit is not kept
	// unloaded peer is unselected: sends ones onto the wired-and line
	assign miso = !load ? 1'b1 : (n >= len) ? ~sh[len - 1] : sh[len - 1];
endmodule
`default_nettype wire

// file: verification/ssp_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module sync_serial_full_duplex_test import ssp_pkg::*;;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic        b_sclk, b_mosi, p_miso, p_ld, p_pol, p_pha;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0]  p_len;
	logic [15:0] p_tx, p_rx;
	ssp_pins_t   pin_i, pin_o, pin_oe;
	int          n_mismatch, samples_checked;

	ssp_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
		.prdata, .irq, .pin_i, .pin_o, .pin_oe);
	ssp_peer i_peer (.sclk(pin_i.sclk), .mosi(pin_i.mosi), .miso(p_miso), .cpol(p_pol), .cpha(p_pha),
		.len(p_len), .tx(p_tx), .load(p_ld), .rx(p_rx));
	// wire levels from the dut's pin enables; the peer's miso is wired-and in
	assign pin_i.sclk = pin_oe.sclk ? pin_o.sclk : b_sclk;
	assign pin_i.mosi = pin_oe.mosi ? pin_o.mosi : b_mosi;
	assign pin_i.miso = (pin_oe.miso ? pin_o.miso : 1'b1) & p_miso;

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// ====================
	// helpers
	task automatic chk(input logic [31:0] g, e, input string m);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic stuck(input string m);
		chk(0, 1, m);
		end_sim;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) stuck("apb hang");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_irq;
		int k;
		k = 0;
		while (irq !== 1'b1 && k < 3000) begin
			@(posedge pclk);
			k++;
		end
		if (k >= 3000) stuck("irq never came");
	endtask
	// ====================
	// scenarios
	task automatic t_regs;
		apb(0, SSP_OFF_CTRL, 0);
		chk(rd, {23'h0, SSP_CTRL_RST}, "ctrl reset");
		apb(0, 8'h1C, 0);
		chk(rd, 0, "unmapped data");
		chk(err, 1'b1, "unmapped error");
		apb(1, SSP_OFF_MASK, 0);
		chk(irq, 1'b0, "masked quiet");
		apb(1, SSP_OFF_PORT, 32'h0000_0077);
		chk(pin_o, 3'b111, "disabled pins");
		chk(pin_oe, 3'b111, "pin enables");
		$display("test regs done");
	endtask
	task automatic t_enable;
		apb(1, SSP_OFF_PORT, 32'h0000_0037);
		apb(1, SSP_OFF_CTRL, 32'h0000_0197);
		chk(pin_o.sclk, 1'b0, "idle low");
		apb(1, SSP_OFF_CTRL, 32'h0000_0097);
		chk(pin_o.sclk, 1'b1, "disabled high");
		apb(1, SSP_OFF_CTRL, 32'h0000_01D7);
		chk(pin_o.sclk, 1'b1, "idle high");
		apb(1, SSP_OFF_CTRL, 32'h0000_0097);
		apb(1, SSP_OFF_PORT, 32'h0000_0036);
		apb(1, SSP_OFF_CTRL, 32'h0000_0197);
		chk(pin_o.sclk, 1'b0, "quiet start");
		apb(1, SSP_OFF_PORT, 32'h0000_0037);
		chk(pin_o.sclk, 1'b0, "clock handed to port");
		apb(1, SSP_OFF_CTRL, 32'h0000_0097);
		$display("test enable done");
	endtask
	task automatic t_master(input logic [1:0] md, input logic [4:0] n, input logic [15:0] tx, pt);
		logic [15:0] m;
		m = 16'hFFFF >> (16 - n);
		{p_pol, p_pha} <= md;
		p_len <= n;
		p_tx <= pt;
		apb(1, SSP_OFF_BAUD, 32'h0000_0003);
		apb(1, SSP_OFF_MASK, 32'h0000_0002);
		apb(1, SSP_OFF_CTRL, {23'h0, 2'b11, md, 1'b1, 4'(n - 5'd1)});
		p_ld <= 1'b1;
		apb(1, SSP_OFF_TXBUF, {16'h0, tx});
		apb(0, SSP_OFF_CTRL, 0);
		chk(rd[SSP_CTRL_BUSY_BIT], 1'b1, "busy set");
		wait_irq;
		apb(0, SSP_OFF_STATUS, 0);
		chk(rd, 32'h0000_0003, "status events");
		apb(0, SSP_OFF_STATUS, 0);
		chk(rd, 0, "status cleared");
		chk(irq, 1'b0, "irq low");
		apb(0, SSP_OFF_RXBUF, 0);
		chk(rd[15:0] & m, pt & m, "rx buffer");
		chk(p_rx & m, tx & m, "peer got");
		chk(pin_o.mosi, tx[0], "mosi holds");
		chk(pin_o.sclk, md[1], "clock idle");
		apb(0, SSP_OFF_CTRL, 0);
		chk(rd[SSP_CTRL_BUSY_BIT], 1'b0, "busy");
		apb(1, SSP_OFF_CTRL, 32'h0000_0080);
		p_ld <= 1'b0;
		$display("test master done");
	endtask
	task automatic t_slave;
		logic [7:0] got, d;
		d = 8'h96;
		apb(1, SSP_OFF_PORT, 32'h0000_0047);
		apb(1, SSP_OFF_CTRL, 32'h0000_0117);
		apb(1, SSP_OFF_TXBUF, 32'h0000_003C);
		repeat (3) @(posedge pclk);
		chk(pin_o.miso, 1'b0, "first bit early");
		for (int i = 7; i >= 0; i--) begin
			b_mosi <= d[i];
			repeat (4) @(posedge pclk);
			got[i] = pin_o.miso;
			b_sclk <= 1'b1;
			repeat (4) @(posedge pclk);
			b_sclk <= 1'b0;
		end
		wait_irq;
		chk(got, 8'h3C, "slave out");
		apb(0, SSP_OFF_RXBUF, 0);
		chk(rd[7:0], d, "slave in");
		apb(1, SSP_OFF_CTRL, 32'h0000_0017);
		$display("test slave done");
	endtask

	initial begin
		{psel, penable, pwrite, p_ld, b_sclk, b_mosi, p_pol, p_pha} = '0;
		{paddr, pwdata, p_len, p_tx} = '0;
		n_mismatch = 0;
		samples_checked = 0;
		presetn = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_enable;
		for (int i = 0; i < 4; i++) t_master(2'(i), 5'd8, 16'h00A5, 16'h005C);
		t_master(2'b00, 5'd2, 16'h0002, 16'h0001);
		t_master(2'b11, 5'd16, 16'hC3A5, 16'h5AF0);
		t_slave;
		end_sim;
	end
endmodule

bind ssp_top ssp_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.pslverr, .prdata, .irq, .pin_i, .pin_o, .pin_oe);
`default_nettype wire
